// *** hdl/lsd_top.sv ***
// line state decoder with detect output, thermal hold and AXI4-Lite status
// assumes pins asynchronous to aclk; AXI master on aclk
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
module lsd_top (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // control pins from the line card controller
  input  wire logic                  detect_out_enable_n,
  input  wire logic                  detector_select,
  input  wire logic                  state_ctrl_hi,
  input  wire logic                  state_ctrl_lo,
  // analog detector and thermal indications
  input  wire logic                  gk_trip,
  input  wire logic                  lc_trip,
  input  wire logic                  rt_trip,
  input  wire logic                  die_over_temp,
  input  wire logic                  die_cooled,
  input  wire logic                  line_fault,
  // open collector detect pin
  output logic                       detect_flag_n_o,
  output logic                       detect_flag_n_oe,
  // line power controls and interrupt
  output logic                       tip_amp_en,
  output logic                       ring_amp_en,
  output logic                       ring_relay_en,
  output logic                       gk_det_en,
  output logic                       lc_det_en,
  output logic                       rt_det_en,
  output logic                       sense_res_en,
  output logic                       irq,
  // AXI4-Lite slave
  input  wire logic [lsd_pkg::AW-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [lsd_pkg::AW-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready
);
  logic [lsd_pkg::SYNC_W-1:0] sync1_ff;
  logic [lsd_pkg::SYNC_W-1:0] sync2_ff;
  logic [lsd_pkg::SYNC_W-1:0] pins;
  logic                       shdn_ff;
  lsd_pkg::lsd_state_t        nxt_state;
  lsd_pkg::lsd_state_t        state_ff;
  logic nxt_tip, nxt_ring, nxt_relay, nxt_gk, nxt_lc, nxt_rt, nxt_sense;
  logic nxt_low;
  logic [lsd_pkg::EV_W-1:0]   evt_stat_ff;
  logic [lsd_pkg::EV_W-1:0]   evt_mask_ff;
  logic [lsd_pkg::EV_W-1:0]   events;
  logic                       aw_got_ff;
  logic                       w_got_ff;
  logic [lsd_pkg::AW-1:0]     awaddr_ff;
  logic [31:0]                wdata_ff;
  logic                       wstrb0_ff;
  logic                       do_write;
  logic                       rd_take;
  logic [31:0]                rd_word;
  logic                       rd_ok;

  assign pins = {line_fault, die_cooled, die_over_temp, rt_trip, lc_trip,
                 gk_trip, state_ctrl_lo, state_ctrl_hi, detector_select,
                 detect_out_enable_n};

  // two-flop synchroniser, second stage is the only reader of the first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_ff <= lsd_pkg::SYNC_RST;
      sync2_ff <= lsd_pkg::SYNC_RST;
    end else begin
      sync1_ff <= pins;
      sync2_ff <= sync1_ff;
    end
  end

  // thermal hold: set hot, release when cooled and fault gone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shdn_ff <= 1'b0;
    end else if (sync2_ff[lsd_pkg::SI_HOT]) begin
      shdn_ff <= 1'b1;
    end else if (sync2_ff[lsd_pkg::SI_COOL] &&
                 !sync2_ff[lsd_pkg::SI_FAULT]) begin
      shdn_ff <= 1'b0;
    end
  end

  lsd_line_decode u_dec (
    .state_ctrl_hi       (sync2_ff[lsd_pkg::SI_HI]),
    .state_ctrl_lo       (sync2_ff[lsd_pkg::SI_LO]),
    .detector_select     (sync2_ff[lsd_pkg::SI_SEL]),
    .detect_out_enable_n (sync2_ff[lsd_pkg::SI_EN_N]),
    .gk_trip             (sync2_ff[lsd_pkg::SI_GK]),
    .lc_trip             (sync2_ff[lsd_pkg::SI_LC]),
    .rt_trip             (sync2_ff[lsd_pkg::SI_RT]),
    .shutdown            (shdn_ff),
    .state               (nxt_state),
    .tip_amp_en          (nxt_tip),
    .ring_amp_en         (nxt_ring),
    .relay_en            (nxt_relay),
    .gk_det_en           (nxt_gk),
    .lc_det_en           (nxt_lc),
    .rt_det_en           (nxt_rt),
    .sense_res_en        (nxt_sense),
    .drive_low           (nxt_low)
  );

  // registered pin drivers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff         <= lsd_pkg::LSD_OPEN;
      tip_amp_en       <= 1'b0;
      ring_amp_en      <= 1'b0;
      ring_relay_en    <= 1'b0;
      gk_det_en        <= 1'b0;
      lc_det_en        <= 1'b0;
      rt_det_en        <= 1'b0;
      sense_res_en     <= 1'b0;
      detect_flag_n_oe <= 1'b0;
      detect_flag_n_o  <= 1'b1;
    end else begin
      state_ff         <= nxt_state;
      tip_amp_en       <= nxt_tip;
      ring_amp_en      <= nxt_ring;
      ring_relay_en    <= nxt_relay;
      gk_det_en        <= nxt_gk;
      lc_det_en        <= nxt_lc;
      rt_det_en        <= nxt_rt;
      sense_res_en     <= nxt_sense;
      // drive low only when tripped and enabled
      detect_flag_n_oe <= nxt_low;
      detect_flag_n_o  <= ~nxt_low;
    end
  end

  // event sources
  always_comb begin
    events = '0;
    events[lsd_pkg::EV_DETECT]   = nxt_low & ~detect_flag_n_oe;
    events[lsd_pkg::EV_SHDN_ON]  = sync2_ff[lsd_pkg::SI_HOT] & ~shdn_ff;
    events[lsd_pkg::EV_SHDN_OFF] = shdn_ff & ~sync2_ff[lsd_pkg::SI_HOT] &
                                   sync2_ff[lsd_pkg::SI_COOL] &
                                   ~sync2_ff[lsd_pkg::SI_FAULT];
    events[lsd_pkg::EV_STATE]    = nxt_state != state_ff;
  end

  // AXI write channel capture
  assign s_axi_awready = ~aw_got_ff;
  assign s_axi_wready  = ~w_got_ff;
  assign do_write      = aw_got_ff & w_got_ff & ~s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      awaddr_ff <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
    end else if (do_write) begin
      aw_got_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_ff  <= 1'b0;
      wdata_ff  <= '0;
      wstrb0_ff <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_ff  <= 1'b1;
      wdata_ff  <= s_axi_wdata;
      wstrb0_ff <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_got_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= lsd_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_ff == lsd_pkg::LINE_STAT_OFS ||
                       awaddr_ff == lsd_pkg::EVT_STAT_OFS ||
                       awaddr_ff == lsd_pkg::EVT_MASK_OFS) ?
                      lsd_pkg::RESP_OKAY : lsd_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_mask_ff <= lsd_pkg::EVT_MASK_RST;
    end else if (do_write && wstrb0_ff &&
                 awaddr_ff == lsd_pkg::EVT_MASK_OFS) begin
      evt_mask_ff <= wdata_ff[lsd_pkg::EV_W-1:0];
    end
  end

  // AXI read channel
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_take       = s_axi_arvalid & s_axi_arready;

  always_comb begin
    rd_word = '0;
    rd_ok   = 1'b1;
    case (s_axi_araddr)
      lsd_pkg::LINE_STAT_OFS: begin
        rd_word[lsd_pkg::LS_STATE_LSB +: 2] =
          sync2_ff[lsd_pkg::SI_HI +: 2] == 2'h0 ? 2'h0 :
          {sync2_ff[lsd_pkg::SI_HI], sync2_ff[lsd_pkg::SI_LO]};
        rd_word[lsd_pkg::LS_SEL_BIT]  = sync2_ff[lsd_pkg::SI_SEL];
        rd_word[lsd_pkg::LS_EN_N_BIT] = sync2_ff[lsd_pkg::SI_EN_N];
        rd_word[lsd_pkg::LS_GK_BIT]   = sync2_ff[lsd_pkg::SI_GK];
        rd_word[lsd_pkg::LS_LC_BIT]   = sync2_ff[lsd_pkg::SI_LC];
        rd_word[lsd_pkg::LS_RT_BIT]   = sync2_ff[lsd_pkg::SI_RT];
        rd_word[lsd_pkg::LS_SHDN_BIT] = shdn_ff;
        rd_word[lsd_pkg::LS_DET_BIT]  = detect_flag_n_oe;
      end
      lsd_pkg::EVT_STAT_OFS: rd_word[lsd_pkg::EV_W-1:0] = evt_stat_ff;
      lsd_pkg::EVT_MASK_OFS: rd_word[lsd_pkg::EV_W-1:0] = evt_mask_ff;
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= lsd_pkg::RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_ok ? lsd_pkg::RESP_OKAY : lsd_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // sticky status, read clears, a new event wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_stat_ff <= '0;
    end else if (rd_take && s_axi_araddr == lsd_pkg::EVT_STAT_OFS) begin
      evt_stat_ff <= events;
    end else begin
      evt_stat_ff <= evt_stat_ff | events;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evt_stat_ff & evt_mask_ff);
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  en_off_a: assert property (
    $past(sync2_ff[lsd_pkg::SI_EN_N]) |-> !detect_flag_n_oe && detect_flag_n_o)
    else $error("detect driven while disabled");
  sel_gk_a: assert property (
    !sync2_ff[lsd_pkg::SI_EN_N] && !sync2_ff[lsd_pkg::SI_SEL] &&
    (nxt_state == lsd_pkg::LSD_ACTIVE) |=>
    detect_flag_n_oe == $past(sync2_ff[lsd_pkg::SI_GK]))
    else $error("ground key not routed");
  decode_st_a: assert property (
    sync2_ff[lsd_pkg::SI_HI] && !sync2_ff[lsd_pkg::SI_LO] |=>
    state_ff == lsd_pkg::LSD_RING)
    else $error("ringing code misdecoded");
  open_off_a: assert property (
    state_ff == lsd_pkg::LSD_OPEN |->
    !(tip_amp_en | ring_amp_en | gk_det_en | lc_det_en | rt_det_en |
      detect_flag_n_oe))
    else $error("open circuit not powered down");
  active_on_a: assert property (
    state_ff == lsd_pkg::LSD_ACTIVE && !$past(shdn_ff) |->
    tip_amp_en && ring_amp_en && gk_det_en && lc_det_en)
    else $error("active state incomplete");
  ring_on_a: assert property (
    state_ff == lsd_pkg::LSD_RING |->
    rt_det_en && !tip_amp_en && !ring_amp_en &&
    (ring_relay_en == !$past(shdn_ff)))
    else $error("ringing outputs wrong");
  stby_on_a: assert property (
    state_ff == lsd_pkg::LSD_STBY |->
    gk_det_en && lc_det_en && !tip_amp_en && !rt_det_en)
    else $error("standby outputs wrong");
  ring_sel_a: assert property (
    state_ff == lsd_pkg::LSD_RING && !$past(sync2_ff[lsd_pkg::SI_SEL]) |->
    !detect_flag_n_oe)
    else $error("ringing detect with select low");
  trip_low_a: assert property (
    !sync2_ff[lsd_pkg::SI_EN_N] && sync2_ff[lsd_pkg::SI_SEL] &&
    sync2_ff[lsd_pkg::SI_LC] && nxt_state == lsd_pkg::LSD_STBY |=>
    detect_flag_n_oe && !detect_flag_n_o)
    else $error("loop trip not shown");
  shdn_hiz_a: assert property (
    sync2_ff[lsd_pkg::SI_HOT] |=> ##1
    !tip_amp_en && !ring_amp_en && !ring_relay_en && !sense_res_en)
    else $error("line not high impedance when hot");
  shdn_hold_a: assert property (
    shdn_ff && !sync2_ff[lsd_pkg::SI_COOL] |=> shdn_ff)
    else $error("shutdown released before cooling");
  comb_lat_a: assert property (
    $stable(sync2_ff) [*3] |-> $stable(state_ff) && $stable(detect_flag_n_oe))
    else $error("decode holds hidden state");
  irq_lvl_a: assert property (
    |(evt_stat_ff & evt_mask_ff) |=> irq)
    else $error("interrupt missing");

  ring_trip_c: cover property (
    state_ff == lsd_pkg::LSD_RING && detect_flag_n_oe);
  offhook_c: cover property (
    state_ff == lsd_pkg::LSD_RING ##[1:20] state_ff == lsd_pkg::LSD_ACTIVE);
  shdn_c: cover property (shdn_ff ##[1:50] !shdn_ff);
  irq_c: cover property (irq ##1 !irq);
endmodule

// *** pkg/lsd_pkg.sv ***
// constants, types and register map of the line state decoder
// assumes one 10 MHz clock and an AXI4-Lite master on the register side
//
// Overview of operation
// - detect output driven only while enable_n is low, else high
// - select low routes ground key in active and standby, high routes loop current or ring trip
// - two control bits decode: 00 open, 01 active, 10 ringing, 11 standby
// - open circuit: all detectors and both line amplifiers powered down
// - active: both amplifiers on, loop current and ground key detectors on
// - ringing: relay driver and ring trip detector on, amplifiers off
// - standby: amplifiers off, sense resistors on, loop and ground key on
// - detect shows selected status per state and select, else stays high
// - over temperature forces high impedance until cooled and fault gone
// - tripped selected detector pulls detect low, untripped leaves high
package lsd_pkg;
  // state control codes, high bit then low bit
  localparam logic [1:0] CTRL_OPEN   = 2'h0;
  localparam logic [1:0] CTRL_ACTIVE = 2'h1;
  localparam logic [1:0] CTRL_RING   = 2'h2;
  localparam logic [1:0] CTRL_STBY   = 2'h3;

  typedef enum logic [3:0] {
    LSD_OPEN   = 4'h1,
    LSD_ACTIVE = 4'h2,
    LSD_RING   = 4'h4,
    LSD_STBY   = 4'h8
  } lsd_state_t;

  // synchronised pin vector layout
  localparam int SYNC_W    = 10;
  localparam int SI_EN_N   = 0;
  localparam int SI_SEL    = 1;
  localparam int SI_HI     = 2;
  localparam int SI_LO     = 3;
  localparam int SI_GK     = 4;
  localparam int SI_LC     = 5;
  localparam int SI_RT     = 6;
  localparam int SI_HOT    = 7;
  localparam int SI_COOL   = 8;
  localparam int SI_FAULT  = 9;
  localparam logic [9:0] SYNC_RST = 10'h001;

  // register map, byte addresses
  localparam int AW = 8;
  localparam logic [7:0] LINE_STAT_OFS = 8'h00;
  localparam logic [7:0] EVT_STAT_OFS  = 8'h04;
  localparam logic [7:0] EVT_MASK_OFS  = 8'h08;

  // line status fields
  localparam int LS_STATE_LSB = 0;
  localparam int LS_SEL_BIT   = 2;
  localparam int LS_EN_N_BIT  = 3;
  localparam int LS_GK_BIT    = 4;
  localparam int LS_LC_BIT    = 5;
  localparam int LS_RT_BIT    = 6;
  localparam int LS_SHDN_BIT  = 7;
  localparam int LS_DET_BIT   = 8;

  // event bits, same layout in status and mask
  localparam int EV_W        = 4;
  localparam int EV_DETECT   = 0;
  localparam int EV_SHDN_ON  = 1;
  localparam int EV_SHDN_OFF = 2;
  localparam int EV_STATE    = 3;
  localparam logic [3:0] EVT_MASK_RST = 4'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** hdl/lsd_line_decode.sv ***
// state decoder and detect multiplexer, purely combinational
// assumes all inputs already synchronised to the block clock
`timescale 1ns/10ps
module lsd_line_decode (
  input  wire logic              state_ctrl_hi,
  input  wire logic              state_ctrl_lo,
  input  wire logic              detector_select,
  input  wire logic              detect_out_enable_n,
  input  wire logic              gk_trip,
  input  wire logic              lc_trip,
  input  wire logic              rt_trip,
  input  wire logic              shutdown,
  output lsd_pkg::lsd_state_t    state,
  output logic                   tip_amp_en,
  output logic                   ring_amp_en,
  output logic                   relay_en,
  output logic                   gk_det_en,
  output logic                   lc_det_en,
  output logic                   rt_det_en,
  output logic                   sense_res_en,
  output logic                   drive_low
);
  always_comb begin
    case ({state_ctrl_hi, state_ctrl_lo})
      lsd_pkg::CTRL_ACTIVE: state = lsd_pkg::LSD_ACTIVE;
      lsd_pkg::CTRL_RING:   state = lsd_pkg::LSD_RING;
      lsd_pkg::CTRL_STBY:   state = lsd_pkg::LSD_STBY;
      default:              state = lsd_pkg::LSD_OPEN;
    endcase
  end

  always_comb begin
    tip_amp_en   = 1'b0;
    ring_amp_en  = 1'b0;
    relay_en     = 1'b0;
    gk_det_en    = 1'b0;
    lc_det_en    = 1'b0;
    rt_det_en    = 1'b0;
    sense_res_en = 1'b0;
    drive_low    = 1'b0;
    case (state)
      lsd_pkg::LSD_ACTIVE: begin
        tip_amp_en  = 1'b1;
        ring_amp_en = 1'b1;
        gk_det_en   = 1'b1;
        lc_det_en   = 1'b1;
        // select picks loop or ground key
        drive_low   = detector_select ? lc_trip : gk_trip;
      end
      // ringing: relay and ring trip only
      lsd_pkg::LSD_RING: begin
        relay_en  = 1'b1;
        rt_det_en = 1'b1;
        drive_low = detector_select & rt_trip;
      end
      // standby: sense resistors and both detectors
      lsd_pkg::LSD_STBY: begin
        sense_res_en = 1'b1;
        gk_det_en    = 1'b1;
        lc_det_en    = 1'b1;
        drive_low    = detector_select ? lc_trip : gk_trip;
      end
      default: begin
        drive_low = 1'b0;
      end
    endcase
    // thermal shutdown leaves the line high impedance
    if (shutdown) begin
      tip_amp_en   = 1'b0;
      ring_amp_en  = 1'b0;
      relay_en     = 1'b0;
      sense_res_en = 1'b0;
    end
    // pull low only when enabled and tripped
    drive_low = drive_low & ~detect_out_enable_n;
  end
endmodule

// *** dv/lsd_ctrl_model.sv ***
// line card controller model driving the state and detect pins
// assumes detect_pin already resolved against its pull-up
`timescale 1ns/10ps
module lsd_ctrl_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [3:0] cmd_pins,
  input  wire logic       cmd_load,
  input  wire logic       auto_answer,
  input  wire logic       detect_pin,
  output logic            detect_out_enable_n,
  output logic            detector_select,
  output logic            state_ctrl_hi,
  output logic            state_ctrl_lo
);
  // pins as {enable_n, select, hi, lo}
  logic [3:0] pins_ff;

  assign {detect_out_enable_n, detector_select} = pins_ff[3:2];
  assign {state_ctrl_hi, state_ctrl_lo}         = pins_ff[1:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins_ff <= 4'h8;
    end else if (cmd_load) begin
      pins_ff <= cmd_pins;
    end else if (auto_answer && !detect_pin &&
                 pins_ff[1:0] == lsd_pkg::CTRL_RING) begin
      pins_ff[1:0] <= lsd_pkg::CTRL_ACTIVE;
    end
  end
endmodule

// *** dv/tb.sv ***
// self-checking bench for the line state decoder
// assumes the controller model drives the pins, bench drives the rest
`timescale 1ns/10ps
module tb;
  localparam int LIMIT = 20000;
  logic                    aclk;
  logic                    aresetn;
  logic [3:0]              cmd_pins;
  logic                    cmd_load;
  logic                    auto_answer;
  logic                    en_n, sel, hi, lo;
  logic                    gk_trip, lc_trip, rt_trip;
  logic                    hot, cool, fault;
  logic                    det_o, det_oe, det_pin;
  logic                    tip, ring, relay, gkd, lcd, rtd, sense, irq;
  logic [lsd_pkg::AW-1:0]  s_axi_awaddr, s_axi_araddr;
  logic                    s_axi_awvalid, s_axi_awready;
  logic [31:0]             s_axi_wdata, s_axi_rdata;
  logic [3:0]              s_axi_wstrb;
  logic                    s_axi_wvalid, s_axi_wready;
  logic [1:0]              s_axi_bresp, s_axi_rresp;
  logic                    s_axi_bvalid, s_axi_bready;
  logic                    s_axi_arvalid, s_axi_arready;
  logic                    s_axi_rvalid, s_axi_rready;
  int                      n_mismatch;
  int                      checked;
  int                      cycles;

  // open collector with pull-up
  assign det_pin = det_oe ? 1'b0 : 1'b1;

  lsd_ctrl_model ctrl (.aclk, .aresetn, .cmd_pins, .cmd_load, .auto_answer,
    .detect_pin(det_pin), .detect_out_enable_n(en_n),
    .detector_select(sel), .state_ctrl_hi(hi), .state_ctrl_lo(lo));

  lsd_top dut (.aclk, .aresetn, .detect_out_enable_n(en_n),
    .detector_select(sel), .state_ctrl_hi(hi), .state_ctrl_lo(lo),
    .gk_trip, .lc_trip, .rt_trip, .die_over_temp(hot), .die_cooled(cool),
    .line_fault(fault), .detect_flag_n_o(det_o), .detect_flag_n_oe(det_oe),
    .tip_amp_en(tip), .ring_amp_en(ring), .ring_relay_en(relay),
    .gk_det_en(gkd), .lc_det_en(lcd), .rt_det_en(rtd), .sense_res_en(sense),
    .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  always #50 aclk = ~aclk;

  task automatic wrap_up;
    if (n_mismatch == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_mismatch++;
      wrap_up;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hf;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask

  // pins {enable_n, select, hi, lo}, trips {rt, lc, gk}
  task automatic set_line(input logic [3:0] p, input logic [2:0] t);
    @(posedge aclk);
    cmd_pins <= p;
    cmd_load <= 1'b1;
    {rt_trip, lc_trip, gk_trip} <= t;
    @(posedge aclk);
    cmd_load <= 1'b0;
    repeat (6) @(posedge aclk);
  endtask

  task automatic set_heat(input logic h, input logic c, input logic f);
    @(posedge aclk);
    {hot, cool, fault} <= {h, c, f};
    repeat (8) @(posedge aclk);
  endtask

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(lsd_pkg::EVT_MASK_OFS, d, r);
    chk("mask reset", {28'h0, lsd_pkg::EVT_MASK_RST}, d);
    axi_wr(lsd_pkg::EVT_MASK_OFS, 32'h0000000f, r);
    axi_rd(lsd_pkg::EVT_MASK_OFS, d, r);
    chk("mask rw", 32'h0000000f, d);
    chk("mask rd resp", {30'h0, lsd_pkg::RESP_OKAY}, {30'h0, r});
    axi_wr(8'h0c, 32'h0, r);
    chk("unmapped wr resp", {30'h0, lsd_pkg::RESP_SLVERR}, {30'h0, r});
    axi_rd(8'h0c, d, r);
    chk("unmapped rd resp", {30'h0, lsd_pkg::RESP_SLVERR}, {30'h0, r});
    axi_wr(lsd_pkg::LINE_STAT_OFS, 32'hffffffff, r);
    chk("ro wr resp", {30'h0, lsd_pkg::RESP_OKAY}, {30'h0, r});
    axi_wr(lsd_pkg::EVT_MASK_OFS, 32'h0, r);
  endtask

  task automatic t_truth;
    logic [6:0] e;
    logic       a, rg, s, dl;
    for (int i = 0; i < 128; i++) begin
      set_line(i[6:3], i[2:0]);
      a  = (i[4:3] == lsd_pkg::CTRL_ACTIVE);
      rg = (i[4:3] == lsd_pkg::CTRL_RING);
      s  = (i[4:3] == lsd_pkg::CTRL_STBY);
      e  = {a, a, rg, a | s, a | s, rg, s};
      dl = !i[6] && (((a || s) && (i[5] ? i[1] : i[0])) || (rg && i[5] && i[2]));
      chk("enables", e, {tip, ring, relay, gkd, lcd, rtd, sense});
      chk("detect pin", !dl, det_pin);
      chk("detect level", !dl, det_o);
    end
  endtask

  task automatic t_thermal;
    logic [31:0] d;
    logic [1:0]  r;
    set_line(4'h1, 3'h0);
    axi_rd(lsd_pkg::EVT_STAT_OFS, d, r);
    set_heat(1'b1, 1'b0, 1'b1);
    chk("amps in shutdown", 2'h0, {tip, ring});
    chk("irq masked", 1'b0, irq);
    axi_wr(lsd_pkg::EVT_MASK_OFS, 32'h1 << lsd_pkg::EV_SHDN_ON, r);
    repeat (3) @(posedge aclk);
    chk("irq unmasked", 1'b1, irq);
    set_heat(1'b0, 1'b0, 1'b1);
    chk("amps still hot", 2'h0, {tip, ring});
    set_heat(1'b0, 1'b1, 1'b1);
    chk("amps fault held", 2'h0, {tip, ring});
    set_heat(1'b0, 1'b1, 1'b0);
    chk("amps resumed", 2'h3, {tip, ring});
    axi_rd(lsd_pkg::EVT_STAT_OFS, d, r);
    chk("thermal events", 32'h6, d);
    repeat (3) @(posedge aclk);
    chk("irq cleared", 1'b0, irq);
    axi_wr(lsd_pkg::EVT_MASK_OFS, 32'h0, r);
  endtask

  task automatic t_ring;
    logic [31:0] d;
    logic [1:0]  r;
    set_line(4'h6, 3'h0);
    chk("ringing relay", 2'h2, {relay, tip});
    @(posedge aclk);
    auto_answer <= 1'b1;
    rt_trip     <= 1'b1;
    for (int k = 0; k < 20 && tip !== 1'b1; k++) @(posedge aclk);
    repeat (2) @(posedge aclk);
    chk("answered", 2'h1, {relay, tip});
    axi_rd(lsd_pkg::LINE_STAT_OFS, d, r);
    chk("line status", 32'h45, d);
    axi_rd(lsd_pkg::EVT_STAT_OFS, d, r);
    chk("ring events", (32'h1 << lsd_pkg::EV_DETECT) |
        (32'h1 << lsd_pkg::EV_STATE), d);
  endtask

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {cmd_pins, cmd_load, auto_answer} = 6'h0;
    {gk_trip, lc_trip, rt_trip, hot, cool, fault} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    n_mismatch = 0;
    checked = 0;
    cycles = 0;
    repeat (16) @(posedge aclk);
    chk("reset outputs", 9'h0,
        {tip, ring, relay, gkd, lcd, rtd, sense, irq, det_oe});
    aresetn <= 1'b1;
    t_regs;
    t_truth;
    t_thermal;
    t_ring;
    wrap_up;
  end
endmodule
